// [logic/sync_serial_cfg.svh]
// register offsets, field positions and reset values for the clocked serial port
`ifndef SYNC_SERIAL_CFG_SVH
`define SYNC_SERIAL_CFG_SVH
`define RSC_OFFSET       8'h00
`define RXBUF_OFFSET     8'h04
`define TSC_OFFSET       8'h08
`define BAUDCTL_OFFSET   8'h0C
`define BAUDHI_OFFSET    8'h10
`define BAUDLO_OFFSET    8'h14
`define TXBUF_OFFSET     8'h18
`define INTCTL_OFFSET    8'h1C
// receive_status_control fields
`define RSC_SERIAL_PORT_ENABLE_BIT     7
`define RSC_RX9_BIT      6
`define RSC_SINGLE_RECEIVE_ENABLE_BIT     5
`define RSC_CONTINUOUS_RECEIVE_ENABLE_BIT     4
`define RSC_FRAMING_ERROR_FLAG_BIT     2
`define RSC_OVERRUN_ERROR_FLAG_BIT     1
`define RSC_RECEIVED_NINTH_BIT_VALUE_BIT     0
// transmit_status_control fields
`define TSC_CLOCK_SOURCE_MASTER_BIT     7
`define TSC_TX9_BIT      6
`define TSC_TRANSMIT_ENABLE_BIT     5
`define TSC_SYNC_BIT     4
`define TSC_SHIFT_REGISTER_EMPTY_BIT     1
`define TSC_TRANSMIT_NINTH_BIT_VALUE_BIT     0
// baud_control fields
`define BC_WIDE_BAUD_DIVISOR_SELECT_BIT     3
// interrupt control fields
`define IC_RCIF_BIT      0
`define IC_TXIF_BIT      1
`define IC_RCIE_BIT      2
`define IC_TXIE_BIT      3
`define IC_GIE_BIT       4
`define IC_PERIPHERAL_INTERRUPT_ENABLE_BIT      5
`define RESET_BYTE       8'h00
`define TSC_RESET        8'h02
`endif

// [logic/sync_serial_pkg.sv]
// types shared by the clocked serial port
package sync_serial_pkg;
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_SHIFT = 3'b010,
    RX_DONE  = 3'b100
  } rx_state_e;
  typedef struct packed {
    logic       serial_port_enable;
    logic       rx9;
    logic       single_receive_enable;
    logic       continuous_receive_enable;
    logic       clock_source_master;
    logic       tx9;
    logic       transmit_enable;
    logic       sync;
    logic       transmit_ninth_bit_value;
    logic       wide_baud_divisor_select;
  } ctrl_s;
endpackage

// [logic/sync_serial_port.sv]
// clocked serial port: master reception, slave transmission, apb registers
// Summary of operation
// [R1] either receive enable starts reception
// [R2] data sampled on falling shift clock
// [R3] single enable receives exactly one word
// [R4] continuous enable receives until cleared
// [R5] continuous wins when both are set
// [R6] word done sets flag, interrupt if enabled
// [R7] ninth bit, errors, data readable
// [R8] clearing continuous enable clears error
// [R9] software loads divisor before reception
// [R10] software sets mode bits before enabling
// [R11] master bit selects internal or external clock
// [R12] slave mode shifts on external clock only
// [R13] first word moves to shifter at once
// [R14] second word waits, empty flag stays clear
// [R15] after shift, second word loads, flag sets
// [R16] transmit empty raises wake and interrupt
// [R17] software sets slave transmit configuration
// [R18] software sets ninth bit before data
// [R19] buffer write starts a transmission
// [R20] empty flag clears only on buffer write
// [R21] shifter empty is read-only status
// [R22] clock runs only while receiving
// [R23] unread word completion flags overrun
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "sync_serial_cfg.svh"
module sync_serial_port
  import sync_serial_pkg::*;
#(
  parameter int DIV_W = 16  // baud divisor width
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        shiftClockIn,
  output logic             shiftClockOut,
  output logic             shiftClockOeN,
  input  wire logic        serialDataIn,
  output logic             serialDataOut,
  output logic             serialDataOeN,
  output logic             irqReq,
  output logic             wakeReq
);
  initial begin
    if (DIV_W != 16) $error("divisor width must be 16");
  end

  ctrl_s       ctl_q;            // software control bits
  logic [7:0]  baudHi_q;         // divisor high byte
  logic [7:0]  baudLo_q;         // divisor low byte
  logic [7:0]  txBuf_q;          // transmit_buffer
  logic        txBufFull_q;      // buffer holds unsent word
  logic        txNinthBuf_q;     // ninth bit latched with buffer
  logic [8:0]  tsr_q;            // transmit shift register
  logic [3:0]  txCnt_q;          // bits left in shifter
  logic [7:0]  rxBuf_q;          // receive_buffer
  logic        received_ninth_bit_value_q;           // received ninth bit
  logic        rxFull_q;         // unread word present
  logic        overrun_error_flag_q;           // overrun error
  logic        rcif_q;           // receive_done_flag
  logic        txif_q;           // transmit_buffer_empty_flag
  logic        rcie_q;           // receive interrupt enable
  logic        txie_q;           // transmit interrupt enable
  logic        gie_q;            // global interrupt enable
  logic        peripheral_interrupt_enable_q;           // peripheral interrupt enable
  logic [8:0]  rsr_q;            // receive shift register
  logic [3:0]  rxCnt_q;          // bits received so far
  rx_state_e   rxState_q;        // receive sequencer
  logic [15:0] baudCnt_q;        // divisor counter
  logic        sck_q;            // master clock level
  logic [2:0]  ckSync_q;         // external clock synchroniser + history
  logic [1:0]  dtSync_q;         // data synchroniser

  // shorthand for bus strobes
  logic wrAcc;
  logic rdAcc;
  assign wrAcc = psel && penable && pwrite;
  assign rdAcc = psel && penable && !pwrite;

  // mode decode
  logic master;
  logic rxOn;
  logic [3:0] rxWords;  // bits per received word, 8 or 9
  assign master  = ctl_q.serial_port_enable && ctl_q.sync && ctl_q.clock_source_master; // [R11]
  assign rxOn    = ctl_q.single_receive_enable || ctl_q.continuous_receive_enable;               // [R1]
  assign rxWords = ctl_q.rx9 ? 4'd9 : 4'd8;

  // pin synchronisers; first stage read only by the second
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ckSync_q <= 3'b000;
      dtSync_q <= 2'b00;
    end else if (clkEn) begin
      ckSync_q <= {ckSync_q[1:0], shiftClockIn};
      dtSync_q <= {dtSync_q[0], serialDataIn};
    end
  end

  // external clock edges, seen from the synchronised copies
  logic extFall;
  logic extRise;
  assign extFall = ckSync_q[2] && !ckSync_q[1];
  assign extRise = !ckSync_q[2] && ckSync_q[1];

  // master baud generator; toggles clock at each divisor expiry
  logic [15:0] divVal;
  logic        baudTick;
  assign divVal   = ctl_q.wide_baud_divisor_select ? {baudHi_q, baudLo_q} : {8'h00, baudLo_q};
  assign baudTick = (baudCnt_q == 16'h0000);
  logic runClk;
  assign runClk = master && (rxState_q == RX_SHIFT); // [R22]
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      baudCnt_q <= 16'h0000;
      sck_q     <= 1'b0;
    end else if (clkEn) begin
      if (!runClk) begin
        baudCnt_q <= divVal;
        sck_q     <= 1'b0; // idle low
      end else if (baudTick) begin
        baudCnt_q <= divVal;
        sck_q     <= !sck_q;
      end else begin
        baudCnt_q <= baudCnt_q - 16'h0001;
      end
    end
  end
  logic mFall;
  assign mFall = runClk && baudTick && sck_q;

  // receive sequencer; samples on falling clock edge
  logic rxDone;
  assign rxDone = (rxState_q == RX_SHIFT) && mFall && (rxCnt_q + 4'd1 == rxWords);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxState_q <= RX_IDLE;
      rsr_q     <= 9'h000;
      rxCnt_q   <= 4'h0;
    end else if (clkEn) begin
      case (rxState_q)
        RX_IDLE: begin
          rxCnt_q <= 4'h0;
          if (master && rxOn) rxState_q <= RX_SHIFT; // [R1]
        end
        RX_SHIFT: begin
          if (!master || !rxOn) begin
            rxState_q <= RX_IDLE; // abort when enables drop
          end else if (mFall) begin
            rsr_q   <= {dtSync_q[1], rsr_q[8:1]}; // [R2] lsb first
            rxCnt_q <= rxCnt_q + 4'd1;
            if (rxDone) rxState_q <= RX_DONE;
          end
        end
        RX_DONE: begin
          rxCnt_q   <= 4'h0;
          // continuous keeps going; single has been cleared
          rxState_q <= ctl_q.continuous_receive_enable ? RX_SHIFT : RX_IDLE; // [R4] [R5]
        end
        default: rxState_q <= RX_IDLE;
      endcase
    end
  end

  // received data, ninth bit, overrun
  logic [8:0] rxWord;
  assign rxWord = ctl_q.rx9 ? {dtSync_q[1], rsr_q[8:1]} : {1'b0, dtSync_q[1], rsr_q[8:2]};
  logic rxBufRd;
  assign rxBufRd = rdAcc && (paddr == `RXBUF_OFFSET);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxBuf_q  <= `RESET_BYTE;
      received_ninth_bit_value_q   <= 1'b0;
      rxFull_q <= 1'b0;
      overrun_error_flag_q   <= 1'b0;
    end else if (clkEn) begin
      if (rxDone) begin
        if (rxFull_q && !rxBufRd) begin
          overrun_error_flag_q <= 1'b1; // [R23] unread word is kept
        end else begin
          rxBuf_q  <= rxWord[7:0]; // [R7]
          received_ninth_bit_value_q   <= rxWord[8];
          rxFull_q <= 1'b1;
        end
      end else if (rxBufRd) begin
        rxFull_q <= 1'b0;
      end
      if (!ctl_q.continuous_receive_enable && !rxDone) overrun_error_flag_q <= 1'b0; // [R8] set wins over clear
    end
  end

  // slave transmitter: load buffer into shifter when empty
  logic tsrEmpty;
  logic txLoad;
  logic txBufWr;
  logic slaveTx;
  assign tsrEmpty = (txCnt_q == 4'h0);
  assign slaveTx  = ctl_q.serial_port_enable && ctl_q.sync && !ctl_q.clock_source_master && ctl_q.transmit_enable; // [R12]
  assign txLoad   = slaveTx && txBufFull_q && tsrEmpty; // [R13] [R15]
  assign txBufWr  = wrAcc && (paddr == `TXBUF_OFFSET);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tsr_q   <= 9'h000;
      txCnt_q <= 4'h0;
    end else if (clkEn) begin
      if (!slaveTx) begin
        txCnt_q <= 4'h0;
      end else if (txLoad) begin
        tsr_q   <= {txNinthBuf_q, txBuf_q}; // [R13]
        txCnt_q <= ctl_q.tx9 ? 4'd9 : 4'd8;
      end else if (!tsrEmpty && extFall) begin
        // shift out on falling external clock; peer samples on rise
        tsr_q   <= {1'b0, tsr_q[8:1]};
        txCnt_q <= txCnt_q - 4'd1;
      end
    end
  end

  // transmit buffer and its empty flag
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txBuf_q      <= `RESET_BYTE;
      txNinthBuf_q <= 1'b0;
      txBufFull_q  <= 1'b0;
      txif_q       <= 1'b1;
    end else if (clkEn) begin
      if (txBufWr) begin
        txBuf_q      <= pwdata[7:0]; // [R19]
        txNinthBuf_q <= ctl_q.transmit_ninth_bit_value;
        txBufFull_q  <= 1'b1;
        txif_q       <= 1'b0; // [R20] [R14]
      end else if (txLoad) begin
        txBufFull_q  <= 1'b0;
        txif_q       <= 1'b1; // [R15] [R20]
      end
    end
  end

  // receive_done_flag: set on each word, cleared by reading the buffer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rcif_q <= 1'b0;
    end else if (clkEn) begin
      if (rxDone) rcif_q <= 1'b1; // [R6] set wins
      else if (rxBufRd) rcif_q <= 1'b0;
    end
  end

  // control registers written over apb
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl_q    <= '0;
      baudHi_q <= `RESET_BYTE;
      baudLo_q <= `RESET_BYTE;
      rcie_q   <= 1'b0;
      txie_q   <= 1'b0;
      gie_q    <= 1'b0;
      peripheral_interrupt_enable_q   <= 1'b0;
    end else if (clkEn) begin
      if (wrAcc) begin
        case (paddr)
          `RSC_OFFSET: begin
            ctl_q.serial_port_enable <= pwdata[`RSC_SERIAL_PORT_ENABLE_BIT];
            ctl_q.rx9  <= pwdata[`RSC_RX9_BIT];
            ctl_q.single_receive_enable <= pwdata[`RSC_SINGLE_RECEIVE_ENABLE_BIT];
            ctl_q.continuous_receive_enable <= pwdata[`RSC_CONTINUOUS_RECEIVE_ENABLE_BIT];
          end
          `TSC_OFFSET: begin
            ctl_q.clock_source_master <= pwdata[`TSC_CLOCK_SOURCE_MASTER_BIT];
            ctl_q.tx9  <= pwdata[`TSC_TX9_BIT];
            ctl_q.transmit_enable <= pwdata[`TSC_TRANSMIT_ENABLE_BIT];
            ctl_q.sync <= pwdata[`TSC_SYNC_BIT];
            ctl_q.transmit_ninth_bit_value <= pwdata[`TSC_TRANSMIT_NINTH_BIT_VALUE_BIT];
          end
          `BAUDCTL_OFFSET: ctl_q.wide_baud_divisor_select <= pwdata[`BC_WIDE_BAUD_DIVISOR_SELECT_BIT];
          `BAUDHI_OFFSET:  baudHi_q    <= pwdata[7:0];
          `BAUDLO_OFFSET:  baudLo_q    <= pwdata[7:0];
          `INTCTL_OFFSET: begin
            rcie_q <= pwdata[`IC_RCIE_BIT];
            txie_q <= pwdata[`IC_TXIE_BIT];
            gie_q  <= pwdata[`IC_GIE_BIT];
            peripheral_interrupt_enable_q <= pwdata[`IC_PERIPHERAL_INTERRUPT_ENABLE_BIT];
          end
          default: ;
        endcase
      end
      // single word done: hardware drops the single enable
      if (rxDone && !ctl_q.continuous_receive_enable) ctl_q.single_receive_enable <= 1'b0; // [R3] [R22]
    end
  end

  // read mux
  logic [7:0] rdByte;
  always_comb begin
    rdByte = 8'h00;
    case (paddr)
      `RSC_OFFSET: begin
        rdByte[`RSC_SERIAL_PORT_ENABLE_BIT] = ctl_q.serial_port_enable;
        rdByte[`RSC_RX9_BIT]  = ctl_q.rx9;
        rdByte[`RSC_SINGLE_RECEIVE_ENABLE_BIT] = ctl_q.single_receive_enable;
        rdByte[`RSC_CONTINUOUS_RECEIVE_ENABLE_BIT] = ctl_q.continuous_receive_enable;
        rdByte[`RSC_OVERRUN_ERROR_FLAG_BIT] = overrun_error_flag_q; // [R7]
        rdByte[`RSC_RECEIVED_NINTH_BIT_VALUE_BIT] = received_ninth_bit_value_q;
      end
      `RXBUF_OFFSET: rdByte = rxBuf_q;
      `TSC_OFFSET: begin
        rdByte[`TSC_CLOCK_SOURCE_MASTER_BIT] = ctl_q.clock_source_master;
        rdByte[`TSC_TX9_BIT]  = ctl_q.tx9;
        rdByte[`TSC_TRANSMIT_ENABLE_BIT] = ctl_q.transmit_enable;
        rdByte[`TSC_SYNC_BIT] = ctl_q.sync;
        rdByte[`TSC_SHIFT_REGISTER_EMPTY_BIT] = tsrEmpty; // [R21]
        rdByte[`TSC_TRANSMIT_NINTH_BIT_VALUE_BIT] = ctl_q.transmit_ninth_bit_value;
      end
      `BAUDCTL_OFFSET: rdByte[`BC_WIDE_BAUD_DIVISOR_SELECT_BIT] = ctl_q.wide_baud_divisor_select;
      `BAUDHI_OFFSET:  rdByte = baudHi_q;
      `BAUDLO_OFFSET:  rdByte = baudLo_q;
      `TXBUF_OFFSET:   rdByte = txBuf_q;
      `INTCTL_OFFSET: begin
        rdByte[`IC_RCIF_BIT] = rcif_q;
        rdByte[`IC_TXIF_BIT] = txif_q;
        rdByte[`IC_RCIE_BIT] = rcie_q;
        rdByte[`IC_TXIE_BIT] = txie_q;
        rdByte[`IC_GIE_BIT]  = gie_q;
        rdByte[`IC_PERIPHERAL_INTERRUPT_ENABLE_BIT] = peripheral_interrupt_enable_q;
      end
      default: rdByte = 8'h00;
    endcase
  end
  logic mapped;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `INTCTL_OFFSET);

  // apb answer: one access cycle, registered
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clkEn) begin
      pready  <= psel && !penable; // ready in first access cycle
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable) prdata <= {24'h00_0000, rdByte};
    end
  end

  // pin drivers and interrupt outputs, all registered
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shiftClockOut <= 1'b0;
      shiftClockOeN <= 1'b1;
      serialDataOut <= 1'b0;
      serialDataOeN <= 1'b1;
      irqReq        <= 1'b0;
      wakeReq       <= 1'b0;
    end else if (clkEn) begin
      shiftClockOut <= sck_q;
      shiftClockOeN <= !master; // [R11] slave leaves clock to peer
      serialDataOut <= tsr_q[0];
      serialDataOeN <= !(slaveTx && !tsrEmpty);
      // wake needs only the source enable; vector needs global enables too
      wakeReq <= (txif_q && txie_q) || (rcif_q && rcie_q); // [R16] [R6]
      irqReq  <= ((txif_q && txie_q) || (rcif_q && rcie_q)) && gie_q && peripheral_interrupt_enable_q; // [R16]
    end
  end

  // single mode: exactly one word then enable drops
  property p_single_stop;
    @(posedge sys_clk) disable iff (rst)
      (rxDone && clkEn && !ctl_q.continuous_receive_enable && !wrAcc) |=> !ctl_q.single_receive_enable;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single enable not cleared"); // [R3]

  // flag sets one cycle after a word completes
  property p_done_flag;
    @(posedge sys_clk) disable iff (rst)
      (rxDone && clkEn) |=> rcif_q;
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("receive flag missing"); // [R6]

  // empty flag only drops on a buffer write
  property p_txif_clear;
    @(posedge sys_clk) disable iff (rst)
      $fell(txif_q) |-> $past(txBufWr);
  endproperty
  a_txif_clear: assert property (p_txif_clear) else $error("empty flag cleared wrongly"); // [R20]

  // shifter load sets the empty flag next cycle
  property p_load_flag;
    @(posedge sys_clk) disable iff (rst)
      (txLoad && clkEn && !txBufWr) |=> (txif_q && !tsrEmpty);
  endproperty
  a_load_flag: assert property (p_load_flag) else $error("load did not set flag"); // [R15]

  // no clock pulses without a receive enable
  property p_clk_gate;
    @(posedge sys_clk) disable iff (rst)
      (!rxOn && clkEn) |=> ##1 !sck_q;
  endproperty
  a_clk_gate: assert property (p_clk_gate) else $error("clock ran while disabled"); // [R22]

  // overrun only with an unread word
  property p_overrun;
    @(posedge sys_clk) disable iff (rst)
      $rose(overrun_error_flag_q) |-> $past(rxFull_q && rxDone);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun without unread word"); // [R23]

  // error clears after continuous enable drops
  property p_err_clear;
    @(posedge sys_clk) disable iff (rst)
      (!ctl_q.continuous_receive_enable && !rxDone && clkEn) |=> !overrun_error_flag_q;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error not cleared"); // [R8]

  // shifter stays non-empty for two cycles after a load
  property p_shift_register_empty;
    @(posedge sys_clk) disable iff (rst)
      (txLoad && clkEn) |=> (txCnt_q != 4'h0) [*2];
  endproperty
  a_shift_register_empty: assert property (p_shift_register_empty) else $error("shifter emptied too early"); // [R21]
endmodule // sync_serial_port

// [sim/serial_peer.sv]
// clocked serial peer: feeds receive bits, makes the slave shift clock, captures sent bits
`timescale 1ns/100ps
module serial_peer #(
  parameter int FRAME_BITS = 8  // clock pulses per transmit frame
) (
  input  wire logic        lineClk,
  input  wire logic        lineData,
  input  wire logic [31:0] rxBits,
  input  wire logic        rxLoad,
  input  wire logic        txGo,
  output logic             peerClk,
  output logic             peerData,
  output logic             txBusy,
  output logic [15:0]      txCap
);
  logic [31:0] rxSr;  // bits still to present, lsb first

  initial begin
    peerClk = 1'b0;
    txBusy  = 1'b0;
    txCap   = 16'h0000;
  end

  // next bit appears 20 ns after the sampling fall, so hold time is met
  always @(posedge rxLoad or negedge lineClk) begin
    if (rxLoad) begin
      rxSr <= rxBits;
    end else begin
      rxSr <= #20 (rxSr >> 1);
    end
  end
  assign peerData = rxSr[0];

  // clock idles low between frames and runs only inside one
  always begin
    @(posedge txGo);
    txBusy = 1'b1;
    repeat (FRAME_BITS) begin
      #62.5 peerClk = 1'b1;
      #62.5 peerClk = 1'b0;
    end
    txBusy = 1'b0;
  end

  // take each sent bit on the rising edge, lsb arrives first
  always @(posedge peerClk) begin
    txCap <= {lineData, txCap[15:1]};
  end
endmodule  // serial_peer

// [sim/sync_serial_master_rx_slave_tx_tb.sv]
// self-checking bench for the clocked serial port
`timescale 1ns/100ps
`include "sync_serial_cfg.svh"
module sync_serial_master_rx_slave_tx_tb;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rxBits, rd;
  logic        shiftClockOut, shiftClockOeN, serialDataOut, serialDataOeN;
  logic        irqReq, wakeReq, peerClk, peerData, rxLoad, txGo, txBusy, er;
  logic [15:0] txCap;
  wire         clkWire  = shiftClockOeN ? peerClk : shiftClockOut;  // resolved clock pin
  wire         dataWire = serialDataOeN ? peerData : serialDataOut;  // resolved data pin
  int          errorCnt = 0, totalChecks = 0, cycles = 0, mFalls = 0;

  sync_serial_port sync_serial_port_i (.sys_clk(sys_clk), .rst(rst), .clkEn(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .shiftClockIn(clkWire),
    .shiftClockOut(shiftClockOut), .shiftClockOeN(shiftClockOeN), .serialDataIn(dataWire),
    .serialDataOut(serialDataOut), .serialDataOeN(serialDataOeN), .irqReq(irqReq),
    .wakeReq(wakeReq));
  serial_peer serial_peer_i (.lineClk(clkWire), .lineData(dataWire), .rxBits(rxBits),
    .rxLoad(rxLoad), .txGo(txGo), .peerClk(peerClk), .peerData(peerData),
    .txBusy(txBusy), .txCap(txCap));

  // 100 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // hang guard, far above the 1300 or so cycles the run needs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errorCnt++;
      stopTest();
    end
  end
  always @(negedge shiftClockOut) mFalls <= mFalls + 1;  // master sampling edges

  task automatic stopTest;
    $display("checks=%0d errors=%0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkPin(input logic got, input logic exp);
    totalChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer, entered just after a rising edge; pready judged at its rising edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge sys_clk) penable <= 1'b1;
    // request held until the edge at which pready is seen high
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    err = pslverr;
    chkPin(pready, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, rd, er);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0000_0000, rd, er);
    chkReg(rd, exp);
  endtask

  // poll a status bit, bounded
  task automatic waitBit(input logic [7:0] a, input int b);
    int n;
    n = 0;
    do begin
      apb(a, 1'b0, 32'h0000_0000, rd, er);
      n++;
    end while (rd[b] !== 1'b1 && n < 200);
    chkPin(rd[b], 1'b1);
  endtask

  task automatic loadPeer(input logic [31:0] bits);
    rxBits <= bits;
    rxLoad <= 1'b1;
    @(posedge sys_clk) rxLoad <= 1'b0;
    @(posedge sys_clk);
  endtask

  // one slave frame clocked by the peer, then let the last fall land
  task automatic peerFrame;
    int n;
    n = 0;
    txGo <= 1'b1;
    @(posedge sys_clk) txGo <= 1'b0;
    repeat (2) @(posedge sys_clk);
    while (txBusy === 1'b1 && n < 500) begin
      n++;
      @(posedge sys_clk);
    end
    repeat (10) @(posedge sys_clk);
  endtask

  // reset values, read-only status and an unmapped address
  task automatic resetValues;
    rdChk(`RSC_OFFSET, 32'h0000_0000);
    rdChk(`TSC_OFFSET, 32'h0000_0002);
    rdChk(`INTCTL_OFFSET, 32'h0000_0002);
    wr(`TSC_OFFSET, 32'h0000_0000);
    rdChk(`TSC_OFFSET, 32'h0000_0002);
    apb(8'h20, 1'b0, 32'h0000_0000, rd, er);
    chkPin(er, 1'b1);
    chkReg(rd, 32'h0000_0000);
  endtask

  // single nine-bit word in master mode, then the clock must stay still
  task automatic masterSingle;
    int f0;
    wr(`BAUDLO_OFFSET, 32'h0000_0008);
    wr(`BAUDCTL_OFFSET, 32'h0000_0000);
    wr(`TSC_OFFSET, 32'h0000_0090);
    wr(`RSC_OFFSET, 32'h0000_00C0);
    wr(`INTCTL_OFFSET, 32'h0000_0034);
    loadPeer(32'h0000_01A5);
    chkPin(shiftClockOeN, 1'b0);
    f0 = mFalls;
    wr(`RSC_OFFSET, 32'h0000_00E0);
    waitBit(`INTCTL_OFFSET, `IC_RCIF_BIT);
    chkPin(irqReq, 1'b1);
    rdChk(`RSC_OFFSET, 32'h0000_00C1);
    rdChk(`RXBUF_OFFSET, 32'h0000_00A5);
    repeat (100) @(posedge sys_clk);
    chkReg(32'(mFalls - f0), 32'h0000_0009);
    chkPin(irqReq, 1'b0);
  endtask

  // both enables set: words keep coming, overrun holds until continuous is cleared
  task automatic masterCont;
    int f0;
    loadPeer(32'h0000_C33C);
    wr(`INTCTL_OFFSET, 32'h0000_0030);
    wr(`RSC_OFFSET, 32'h0000_00B0);
    waitBit(`INTCTL_OFFSET, `IC_RCIF_BIT);
    chkPin(irqReq, 1'b0);
    rdChk(`RXBUF_OFFSET, 32'h0000_003C);
    waitBit(`INTCTL_OFFSET, `IC_RCIF_BIT);
    rdChk(`RXBUF_OFFSET, 32'h0000_00C3);
    waitBit(`RSC_OFFSET, `RSC_OVERRUN_ERROR_FLAG_BIT);
    rdChk(`RSC_OFFSET, 32'h0000_00B2);
    wr(`RSC_OFFSET, 32'h0000_0080);
    rdChk(`RSC_OFFSET, 32'h0000_0080);
    rdChk(`RXBUF_OFFSET, 32'h0000_0000);
    f0 = mFalls;
    repeat (100) @(posedge sys_clk);
    chkReg(32'(mFalls - f0), 32'h0000_0000);
  endtask

  // two words queued in slave mode, clock from the peer only
  task automatic slaveTx;
    wr(`TSC_OFFSET, 32'h0000_0030);
    wr(`RSC_OFFSET, 32'h0000_0080);
    wr(`INTCTL_OFFSET, 32'h0000_0008);
    wr(`TXBUF_OFFSET, 32'h0000_005A);
    wr(`TXBUF_OFFSET, 32'h0000_0096);
    rdChk(`INTCTL_OFFSET, 32'h0000_0008);
    rdChk(`TSC_OFFSET, 32'h0000_0030);
    chkPin(wakeReq, 1'b0);
    chkPin(serialDataOeN, 1'b0);
    peerFrame();
    chkReg({24'h00_0000, txCap[15:8]}, 32'h0000_005A);
    rdChk(`INTCTL_OFFSET, 32'h0000_000A);
    chkPin(wakeReq, 1'b1);
    chkPin(irqReq, 1'b0);
    wr(`INTCTL_OFFSET, 32'h0000_0008);
    rdChk(`INTCTL_OFFSET, 32'h0000_000A);
    peerFrame();
    chkReg({24'h00_0000, txCap[15:8]}, 32'h0000_0096);
    rdChk(`TSC_OFFSET, 32'h0000_0032);
    wr(`INTCTL_OFFSET, 32'h0000_0038);
    repeat (3) @(posedge sys_clk);
    chkPin(irqReq, 1'b1);
  endtask

  // reset, then the scenarios in order
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    rxBits = 32'h0000_0000;
    rxLoad = 1'b0;
    txGo = 1'b0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    resetValues();
    masterSingle();
    masterCont();
    slaveTx();
    stopTest();
  end
endmodule  // sync_serial_master_rx_slave_tx_tb
